// >>> rtl/cfg_gate_regs.vh
// Constants for the serial radio configuration gate
`ifndef CFG_GATE_REGS_VH
`define CFG_GATE_REGS_VH
`define CLK_HZ 32'd20000000
`define SEC_CNT_MAX 25'h1312CFF
`define CFG_TIMER_DEF 8'h3C
`define CFG_NO_REMOTE 8'h00
`define CFG_LOCAL_ONLY 8'hFD
`define CFG_REMOTE_ONLY 8'hFE
`define CFG_BOTH 8'hFF
`define MODE_SLAVE 2'h0
`define MODE_MASTER 2'h1
`define MODE_TRIGGER 2'h2
`define MODE_AUTO 2'h3
`define IDLE_DEF 8'h05
`define CH_DOLLAR 8'h24
`define CH_DASH 8'h2D
`define CH_CR 8'h0D
`define CH_C 8'h43
`define CH_M 8'h4D
`define CH_D 8'h44
`define CH_E 8'h45
`define CH_N 8'h4E
`define CH_A 8'h41
`define CH_O 8'h4F
`define CH_K 8'h4B
`define CH_R 8'h52
`define CH_Q 8'h3F
`define BAUD_DEF 32'd115200
`define SCAN_WIN_DEF 16'h0200
`define SCAN_INT_DEF 16'h0800
`define COD_DEF 16'h1F00
`define BREAK_DEF 8'h00
`define DF_TOGGLES 3'h3
`define RC_TOGGLES 3'h2
`define BLINK_HALF 25'h4C4B3F
`define SW_SETTLE 25'h5
`define ADDR_MODE 12'h000
`define ADDR_TIMER 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_IDLE 12'h00C
`define ADDR_SCAN 12'h010
`define ADDR_RESULT 12'h014
`define ADDR_SERIAL 12'h018
`define ADDR_BREAK 12'h01C
`define RES_AOK 2'h0
`define RES_ERR 2'h1
`define RES_UNK 2'h2
`endif

// >>> rtl/reply_rom.v
// Reply string memory with registered read data
`timescale 1ns/100ps
module reply_rom (
    input wire clk_sys, // System clock
    input wire [3:0] addr, // Character index
    output reg [7:0] data_r // Registered character
);
`include "cfg_gate_regs.vh"
    always @(posedge clk_sys) begin
        case (addr)
            4'h0: data_r <= `CH_C;
            4'h1: data_r <= `CH_M;
            4'h2: data_r <= `CH_D;
            4'h3: data_r <= `CH_E;
            4'h4: data_r <= `CH_N;
            4'h5: data_r <= `CH_D;
            4'h6: data_r <= `CH_A;
            4'h7: data_r <= `CH_O;
            4'h8: data_r <= `CH_K;
            4'h9: data_r <= `CH_E;
            4'hA: data_r <= `CH_R;
            4'hB: data_r <= `CH_R;
            4'hC: data_r <= `CH_Q;
            default: data_r <= `CH_CR;
        endcase
    end
endmodule

// >>> rtl/serial_radio_config_gate.v
// Command mode gate and connection policy for a serial radio
`timescale 1ns/100ps
module serial_radio_config_gate (
    input wire clk_sys, // System clock, 20 MHz
    input wire reset, // Synchronous reset, active high
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB write
    input wire [11:0] paddr, // APB address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error
    input wire [7:0] loc_data, // Byte from local UART
    input wire loc_valid, // Local byte strobe
    input wire [7:0] rem_data, // Byte from wireless link
    input wire rem_valid, // Remote byte strobe
    input wire link_up, // Wireless connection exists (pin)
    input wire sw_default, // Factory default switch (pin)
    input wire sw_auto_conn, // Auto-connect switch (pin)
    input wire sw_auto_pair, // Auto-pairing switch (pin)
    output reg [7:0] fwd_data, // Byte passed to other side
    output reg fwd_to_rem, // Forward strobe toward link
    output reg fwd_to_loc, // Forward strobe toward UART
    output reg [7:0] rpl_data, // Reply character
    output reg rpl_valid, // Reply strobe
    output reg rpl_to_rem, // Reply goes to remote side
    output reg cmd_mode, // In command mode
    output reg [7:0] cmd_byte, // Byte for the command parser
    output reg cmd_valid, // Parser byte strobe
    output reg cmd_remote, // Command source is remote
    output reg discoverable, // Inquiry scan enabled
    output reg connectable, // Page scan enabled
    output reg connect_req, // Request connection to stored peer
    output reg disconnect_req, // Request drop of the link
    output reg pair_search, // Master search for matching class
    output reg pair_advertise, // Slave advertises matching class
    output reg green_led, // Green indicator
    output reg factory_reboot, // Defaults restored, reboot pulse
    output reg [15:0] scan_window, // Inquiry and page scan window
    output reg [15:0] scan_interval // Fixed scan interval
);
`include "cfg_gate_regs.vh"
    localparam ST_IDLE = 2'd0;
    localparam ST_SEND = 2'd1;
    localparam ST_WAIT = 2'd2;

    reg [1:0] mode_r;
    reg pair_r;
    reg [7:0] timer_set_r;
    reg [7:0] idle_set_r;
    reg [7:0] break_chr_r;
    reg [15:0] scan_win_r;
    reg [24:0] div_r;
    reg tick_r;
    reg [7:0] sec_r;
    reg [7:0] idle_cnt_r;
    reg [1:0] dollar_r;
    reg [1:0] dash_r;
    reg cmd_r;
    reg cmd_src_r;
    reg [1:0] st_r;
    reg [3:0] rp_ptr_r;
    reg [3:0] rp_end_r;
    reg rp_rem_r;
    reg [2:0] sw_sync_r;
    reg [2:0] auto_sync_r;
    reg [2:0] pair_sync_r;
    reg [2:0] link_sync_r;
    reg sw_state_r;
    reg sw_start_r;
    reg [2:0] tog_r;
    reg settled_r;
    reg remote_prep_r;
    reg [24:0] blink_r;
    reg started_r;
    reg [1:0] res_r;
    reg res_pend_r;
    wire [7:0] rom_q;

    reply_rom u_rom (
        .clk_sys(clk_sys),
        .addr(rp_ptr_r),
        .data_r(rom_q)
    );

    // Pin inputs: three flops, change counts when last two agree
    always @(posedge clk_sys) begin
        if (reset) begin
            sw_sync_r <= 3'h0;
            auto_sync_r <= 3'h0;
            pair_sync_r <= 3'h0;
            link_sync_r <= 3'h0;
        end else begin
            sw_sync_r <= {sw_sync_r[1:0], sw_default};
            auto_sync_r <= {auto_sync_r[1:0], sw_auto_conn};
            pair_sync_r <= {pair_sync_r[1:0], sw_auto_pair};
            link_sync_r <= {link_sync_r[1:0], link_up};
        end
    end
    reg link_r, auto_sw_r, pair_sw_r;
    always @(posedge clk_sys) begin
        if (reset) begin
            link_r <= 1'b0;
            auto_sw_r <= 1'b0;
            pair_sw_r <= 1'b0;
            sw_state_r <= 1'b0;
        end else begin
            if (link_sync_r[1] == link_sync_r[2])
                link_r <= link_sync_r[2];
            if (auto_sync_r[1] == auto_sync_r[2])
                auto_sw_r <= auto_sync_r[2];
            if (pair_sync_r[1] == pair_sync_r[2])
                pair_sw_r <= pair_sync_r[2];
            if (sw_sync_r[1] == sw_sync_r[2])
                sw_state_r <= sw_sync_r[2];
        end
    end

    // One hertz tick and seconds since power-up
    always @(posedge clk_sys) begin
        if (reset) begin
            div_r <= 25'h0;
            tick_r <= 1'b0;
            sec_r <= 8'h00;
        end else begin
            tick_r <= (div_r == `SEC_CNT_MAX);
            div_r <= (div_r == `SEC_CNT_MAX) ? 25'h0 : div_r + 25'h1;
            if (tick_r && sec_r != 8'hFF)
                sec_r <= sec_r + 8'h01;
        end
    end

    // Entry permission per side from timer setting
    wire in_window = (sec_r < timer_set_r);
    wire is_cont = (timer_set_r >= `CFG_LOCAL_ONLY);
    wire win_open = in_window && !is_cont && timer_set_r != `CFG_NO_REMOTE;
    wire is_auto = (mode_r == `MODE_AUTO) || auto_sw_r;
    reg loc_ok, rem_ok;
    always @* begin
        loc_ok = !link_r || win_open;
        rem_ok = link_r && win_open;
        if (timer_set_r == `CFG_LOCAL_ONLY) begin
            loc_ok = 1'b1;
            rem_ok = 1'b0;
        end else if (timer_set_r == `CFG_REMOTE_ONLY) begin
            loc_ok = !link_r;
            rem_ok = link_r;
        end else if (timer_set_r == `CFG_BOTH) begin
            loc_ok = 1'b1;
            rem_ok = link_r;
        end
        if (is_auto) begin
            loc_ok = 1'b0;
            rem_ok = 1'b0;
        end
    end

    // Escape detection, command mode and forwarding
    wire in_src = rem_valid ? 1'b1 : 1'b0;
    wire in_val = loc_valid || rem_valid;
    wire [7:0] in_byte = rem_valid ? rem_data : loc_data;
    wire src_ok = in_src ? rem_ok : loc_ok;
    reg link_sync_prev_r;
    wire link_rise = link_r && !link_sync_prev_r;
    reg start_rpl;
    reg [3:0] start_idx, end_idx;
    always @(posedge clk_sys) begin
        if (reset) begin
            dollar_r <= 2'h0;
            dash_r <= 2'h0;
            cmd_r <= 1'b0;
            cmd_src_r <= 1'b0;
            fwd_data <= 8'h00;
            fwd_to_rem <= 1'b0;
            fwd_to_loc <= 1'b0;
            cmd_byte <= 8'h00;
            cmd_valid <= 1'b0;
            start_rpl <= 1'b0;
            start_idx <= 4'h0;
            end_idx <= 4'h0;
            link_sync_prev_r <= 1'b0;
        end else begin
            link_sync_prev_r <= link_r;
            fwd_to_rem <= 1'b0;
            fwd_to_loc <= 1'b0;
            cmd_valid <= 1'b0;
            start_rpl <= 1'b0;
            if (cmd_r && link_rise && !cmd_src_r) begin
                cmd_r <= 1'b0;
                dash_r <= 2'h0;
            end else if (in_val && !cmd_r) begin
                fwd_data <= in_byte;
                fwd_to_rem <= !in_src;
                fwd_to_loc <= in_src;
                if (in_byte == `CH_DOLLAR && src_ok) begin
                    dollar_r <= dollar_r + 2'h1;
                    if (dollar_r == 2'h2) begin
                        cmd_r <= 1'b1;
                        cmd_src_r <= in_src;
                        dollar_r <= 2'h0;
                        start_rpl <= 1'b1;
                        start_idx <= 4'h0;
                        end_idx <= 4'h2;
                    end
                end else begin
                    dollar_r <= 2'h0;
                end
            end else if (in_val && in_src == cmd_src_r) begin
                cmd_byte <= in_byte;
                cmd_valid <= 1'b1;
                if (in_byte == `CH_DASH)
                    dash_r <= (dash_r == 2'h3) ? 2'h3 : dash_r + 2'h1;
                else if (in_byte == `CH_CR && dash_r == 2'h3) begin
                    cmd_r <= 1'b0;
                    dash_r <= 2'h0;
                    start_rpl <= 1'b1;
                    start_idx <= 4'h3;
                    end_idx <= 4'h5;
                end else
                    dash_r <= 2'h0;
            end else if (res_pend_r && cmd_r) begin
                start_rpl <= 1'b1;
                start_idx <= (res_r == `RES_AOK) ? 4'h6 :
                    (res_r == `RES_ERR) ? 4'h9 : 4'hC;
                end_idx <= (res_r == `RES_AOK) ? 4'h8 :
                    (res_r == `RES_ERR) ? 4'hB : 4'hC;
            end
        end
    end

    // Reply sequencer reads characters from the string memory
    always @(posedge clk_sys) begin
        if (reset) begin
            st_r <= ST_IDLE;
            rp_ptr_r <= 4'h0;
            rp_end_r <= 4'h0;
            rp_rem_r <= 1'b0;
            rpl_data <= 8'h00;
            rpl_valid <= 1'b0;
            rpl_to_rem <= 1'b0;
        end else begin
            rpl_valid <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    if (start_rpl) begin
                        rp_ptr_r <= start_idx;
                        rp_end_r <= end_idx;
                        rp_rem_r <= cmd_src_r;
                        st_r <= ST_WAIT;
                    end
                end
                ST_WAIT: st_r <= ST_SEND;
                ST_SEND: begin
                    rpl_data <= rom_q;
                    rpl_valid <= 1'b1;
                    rpl_to_rem <= rp_rem_r;
                    if (rp_ptr_r == rp_end_r)
                        st_r <= ST_IDLE;
                    else begin
                        rp_ptr_r <= rp_ptr_r + 4'h1;
                        st_r <= ST_WAIT;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // Connection policy per operating mode
    always @(posedge clk_sys) begin
        if (reset) begin
            discoverable <= 1'b1;
            connectable <= 1'b1;
            connect_req <= 1'b0;
            disconnect_req <= 1'b0;
            pair_search <= 1'b0;
            pair_advertise <= 1'b0;
            idle_cnt_r <= 8'h00;
            started_r <= 1'b0;
        end else begin
            connect_req <= 1'b0;
            disconnect_req <= 1'b0;
            discoverable <= (mode_r == `MODE_SLAVE) && scan_win_r != 16'h0;
            connectable <= (mode_r == `MODE_SLAVE) && scan_win_r != 16'h0;
            // above
            pair_search <= (pair_r || pair_sw_r) && mode_r != `MODE_SLAVE;
            pair_advertise <= (pair_r || pair_sw_r) && mode_r == `MODE_SLAVE;
            // above
            // Power-up connect waits until the switch inputs have settled
            if (settled_r && !started_r) begin
                started_r <= 1'b1;
                connect_req <= is_auto;
            end
            if (mode_r == `MODE_TRIGGER) begin
                if (loc_valid && !link_r && !cmd_r)
                    connect_req <= 1'b1;
                if (loc_valid || rem_valid)
                    idle_cnt_r <= 8'h00;
                else if (tick_r && link_r)
                    idle_cnt_r <= idle_cnt_r + 8'h01;
                if (link_r && (idle_cnt_r >= idle_set_r ||
                    (loc_valid && loc_data == break_chr_r
                     && break_chr_r != `BREAK_DEF))) begin
                    disconnect_req <= 1'b1;
                    idle_cnt_r <= 8'h00;
                end
            end
        end
    end

    // Factory default switch toggling
    reg sw_prev_r;
    always @(posedge clk_sys) begin
        if (reset) begin
            sw_prev_r <= 1'b0;
            sw_start_r <= 1'b0;
            tog_r <= 3'h0;
            settled_r <= 1'b0;
            remote_prep_r <= 1'b0;
            blink_r <= 25'h0;
            green_led <= 1'b0;
            factory_reboot <= 1'b0;
        end else begin
            factory_reboot <= 1'b0;
            sw_prev_r <= sw_state_r;
            // Switch level at power-up, taken once the filter has settled
            if (!settled_r && blink_r == `SW_SETTLE) begin
                settled_r <= 1'b1;
                sw_start_r <= sw_state_r;
            end
            if (sw_start_r && sw_prev_r && !sw_state_r)
                tog_r <= tog_r + 3'h1;
            if (tog_r == `DF_TOGGLES) begin
                factory_reboot <= 1'b1;
                tog_r <= 3'h0;
                remote_prep_r <= 1'b0;
            end else if (tog_r == `RC_TOGGLES)
                remote_prep_r <= 1'b1;
            blink_r <= (blink_r == `BLINK_HALF) ? 25'h0 : blink_r + 25'h1;
            if (remote_prep_r && blink_r == `BLINK_HALF)
                green_led <= !green_led;
            else if (!remote_prep_r)
                green_led <= link_r;
        end
    end

    // APB register file
    wire acc = psel && penable;
    always @(posedge clk_sys) begin
        if (reset || factory_reboot) begin
            mode_r <= `MODE_SLAVE;
            pair_r <= 1'b0;
            timer_set_r <= `CFG_TIMER_DEF;
            idle_set_r <= `IDLE_DEF;
            break_chr_r <= `BREAK_DEF;
            scan_win_r <= `SCAN_WIN_DEF;
            res_r <= `RES_AOK;
            res_pend_r <= 1'b0;
        end else begin
            res_pend_r <= 1'b0;
            if (acc && pwrite && pready) begin
                case (paddr)
                    `ADDR_MODE: begin
                        mode_r <= pwdata[1:0];
                        pair_r <= pwdata[4];
                    end
                    `ADDR_TIMER: timer_set_r <= pwdata[7:0];
                    `ADDR_IDLE: idle_set_r <= (pwdata[7:0] == 8'h00) ?
                        8'h01 : pwdata[7:0];
                    `ADDR_SCAN: scan_win_r <= pwdata[15:0];
                    `ADDR_RESULT: begin
                        res_r <= pwdata[1:0];
                        res_pend_r <= 1'b1;
                    end
                    `ADDR_BREAK: break_chr_r <= pwdata[7:0];
                    default: res_pend_r <= 1'b0;
                endcase
            end
        end
    end
    always @(posedge clk_sys) begin
        if (reset) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            cmd_mode <= 1'b0;
            cmd_remote <= 1'b0;
            scan_window <= `SCAN_WIN_DEF;
            scan_interval <= `SCAN_INT_DEF;
        end else begin
            cmd_mode <= cmd_r;
            cmd_remote <= cmd_src_r;
            scan_window <= scan_win_r;
            scan_interval <= `SCAN_INT_DEF;
            pready <= psel && !pready;
            pslverr <= 1'b0;
            if (psel && !pready) begin
                pslverr <= (paddr > `ADDR_BREAK) || (paddr[1:0] != 2'h0);
                case (paddr)
                    `ADDR_MODE: prdata <= {27'h0, pair_r, 2'h0, mode_r};
                    `ADDR_TIMER: prdata <= {24'h0, timer_set_r};
                    `ADDR_STATUS: prdata <= {12'h0, sec_r, 6'h0,
                        remote_prep_r, link_r, cmd_src_r, loc_ok, rem_ok,
                        cmd_r};
                    `ADDR_IDLE: prdata <= {24'h0, idle_set_r};
                    `ADDR_SCAN: prdata <= {`SCAN_INT_DEF, scan_win_r};
                    `ADDR_RESULT: prdata <= {30'h0, res_r};
                    `ADDR_SERIAL: prdata <= `BAUD_DEF;
                    `ADDR_BREAK: prdata <= {24'h0, break_chr_r};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end
endmodule

// >>> verif/gate_props_properties.sv
// Port properties of the serial radio configuration gate
`timescale 1ns/100ps
`include "cfg_gate_regs.vh"
module gate_props (
    input logic clk_sys, // Clock
    input logic reset, // Reset
    input logic psel, // Select
    input logic penable, // Enable
    input logic pready, // Ready
    input logic pslverr, // Error
    input logic [7:0] loc_data, // Local byte
    input logic loc_valid, // Local strobe
    input logic [7:0] rem_data, // Link byte
    input logic rem_valid, // Link strobe
    input logic link_up, // Link present
    input logic sw_auto_conn, // Auto switch
    input logic [7:0] fwd_data, // Forward byte
    input logic fwd_to_rem, // To link
    input logic fwd_to_loc, // To UART
    input logic [7:0] rpl_data, // Reply byte
    input logic rpl_valid, // Reply strobe
    input logic cmd_mode, // Command mode
    input logic [7:0] cmd_byte, // Parser byte
    input logic cmd_valid, // Parser strobe
    input logic cmd_remote, // Remote source
    input logic factory_reboot, // Reboot pulse
    input logic [15:0] scan_interval // Scan interval
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence setup_phase;
        psel && !penable;
    endsequence
    sequence cmd_opens;
        !cmd_mode ##1 cmd_mode;
    endsequence
    sequence c_reply;
        rpl_valid && rpl_data == `CH_C;
    endsequence
    a_apb_answer: assert property (setup_phase |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_entry_reply: assert property (cmd_opens |-> ##[0:6] c_reply)
        else $error("no reply on entry");
    a_auto_blocks: assert property (
        sw_auto_conn [*8] |-> !$rose(cmd_mode))
        else $error("entry in auto mode");
    a_link_exits: assert property (
        $rose(link_up) && cmd_mode && !cmd_remote |-> ##[1:12] !cmd_mode)
        else $error("link did not end command mode");
    a_loc_forward: assert property (
        !cmd_mode && loc_valid && !rem_valid
        |=> fwd_to_rem && fwd_data == $past(loc_data))
        else $error("local byte not forwarded");
    a_rem_forward: assert property (
        !cmd_mode && rem_valid |=> fwd_to_loc && fwd_data == $past(rem_data))
        else $error("link byte not forwarded");
    a_cmd_feed: assert property (
        cmd_mode && !cmd_remote && loc_valid && !rem_valid
        && loc_data != `CH_CR |=> cmd_valid && cmd_byte == $past(loc_data))
        else $error("parser not fed");
    a_scan_fixed: assert property (scan_interval == `SCAN_INT_DEF)
        else $error("scan interval changed");
    a_reboot_pulse: assert property (factory_reboot |=> !factory_reboot)
        else $error("reboot pulse too long");
endmodule
bind serial_radio_config_gate gate_props gp_u (.clk_sys, .reset, .psel,
    .penable, .pready, .pslverr, .loc_data, .loc_valid, .rem_data,
    .rem_valid, .link_up, .sw_auto_conn, .fwd_data, .fwd_to_rem, .fwd_to_loc,
    .rpl_data, .rpl_valid, .cmd_mode, .cmd_byte, .cmd_valid, .cmd_remote,
    .factory_reboot, .scan_interval);

// >>> verif/radio_peer.sv
// Local host and wireless peer: byte senders and reply capture
`timescale 1ns/100ps
module radio_peer (
    input wire clk_sys, // Clock
    output logic [7:0] loc_data, // Local byte
    output logic loc_valid, // Local strobe
    output logic [7:0] rem_data, // Link byte
    output logic rem_valid, // Link strobe
    output logic link_up, // Link present
    input wire [7:0] rpl_data, // Reply byte
    input wire rpl_valid // Reply strobe
);
    logic [7:0] rq[$];
    initial begin
        loc_data = 8'h00;
        rem_data = 8'h00;
        loc_valid = 1'h0;
        rem_valid = 1'h0;
        link_up = 1'h0;
    end
    always @(posedge clk_sys) begin
        if (rpl_valid) begin
            rq.push_back(rpl_data);
        end
    end
    // One byte per cycle, then the idle line carries inverted junk
    task send(input bit rem, input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge clk_sys);
            if (rem) begin
                rem_data <= s[i];
                rem_valid <= 1'h1;
            end else begin
                loc_data <= s[i];
                loc_valid <= 1'h1;
            end
        end
        @(posedge clk_sys);
        loc_valid <= 1'h0;
        rem_valid <= 1'h0;
        loc_data <= ~loc_data;
        rem_data <= ~rem_data;
    endtask
endmodule

// >>> verif/serial_radio_config_gate_test.sv
// Self-checking bench for the serial radio configuration gate
`timescale 1ns/100ps
`include "cfg_gate_regs.vh"
module serial_radio_config_gate_test;
    logic clk_sys, reset, psel, penable, pwrite, last_err;
    logic sw_default, sw_auto_conn, sw_auto_pair;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    wire [31:0] prdata;
    wire [7:0] loc_data, rem_data, fwd_data, rpl_data, cmd_byte;
    wire [15:0] scan_window, scan_interval;
    wire pready, pslverr, loc_valid, rem_valid, link_up, fwd_to_rem;
    wire fwd_to_loc, rpl_valid, rpl_to_rem, cmd_mode, cmd_valid;
    wire cmd_remote, discoverable, connectable, connect_req;
    wire disconnect_req, pair_search, pair_advertise, green_led;
    wire factory_reboot;
    int fails, total_checks, n;
    string rs[3] = '{"AOK", "ERR", "?"};
    serial_radio_config_gate dut_u (.clk_sys, .reset, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .loc_data,
        .loc_valid, .rem_data, .rem_valid, .link_up, .sw_default,
        .sw_auto_conn, .sw_auto_pair, .fwd_data, .fwd_to_rem, .fwd_to_loc,
        .rpl_data, .rpl_valid, .rpl_to_rem, .cmd_mode, .cmd_byte, .cmd_valid,
        .cmd_remote, .discoverable, .connectable, .connect_req,
        .disconnect_req, .pair_search, .pair_advertise, .green_led,
        .factory_reboot, .scan_window, .scan_interval);
    radio_peer peer_u (.clk_sys, .loc_data, .loc_valid, .rem_data,
        .rem_valid, .link_up, .rpl_data, .rpl_valid);
    initial begin
        clk_sys = 1'h0;
        forever #25 clk_sys = ~clk_sys;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task give_up;
        fails++;
        tally_and_finish;
    endtask
    task idle(input int c);
        repeat (c) @(posedge clk_sys);
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_sys);
            if (pready === 1'h1) break;
        end
        if (k == 20) give_up;
        rd = prdata;
        last_err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task expect_rpl(input string s);
        int k;
        for (k = 0; k < 200 && peer_u.rq.size() < s.len(); k++) begin
            @(posedge clk_sys);
        end
        if (k == 200) give_up;
        for (k = 0; k < s.len(); k++) check(peer_u.rq[k], s[k]);
        idle(6);
        peer_u.rq.delete();
    endtask
    task try_in(input bit rem, input bit ok);
        peer_u.send(rem, "$$$");
        if (ok) begin
            expect_rpl("CMD");
            check(cmd_mode, 1'h1);
            check(cmd_remote, rem);
            check(rpl_to_rem, rem);
        end else begin
            idle(20);
            check(cmd_mode, 1'h0);
            check(peer_u.rq.size(), 0);
        end
    endtask
    task leave(input bit rem);
        peer_u.send(rem, "---\015");
        expect_rpl("END");
        check(cmd_mode, 1'h0);
    endtask
    initial begin
        {psel, penable, pwrite, sw_auto_conn, sw_auto_pair} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        reset = 1'h1;
        sw_default = 1'h1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'h0;
        // Switch on at start, then toggled five times: three on-to-off
        repeat (5) begin
            idle(10);
            sw_default <= ~sw_default;
        end
        for (n = 0; n < 60 && factory_reboot !== 1'h1; n++) idle(1);
        check(factory_reboot, 1'h1);
        if (n == 60) give_up;
        idle(4);
        check(discoverable, 1'h1);
        check(connectable, 1'h1);
        check(scan_window, 16'h0200);
        check(scan_interval, 16'h0800);
        apb(0, `ADDR_TIMER, 0);
        check(rd, 32'h0000003C);
        apb(0, `ADDR_SERIAL, 0);
        check(rd, 32'h0001C200);
        apb(0, 12'h020, 0);
        check(last_err, 1'h1);
        check(rd, 32'h00000000);
        apb(1, `ADDR_MODE, 32'h11);
        idle(3);
        check({discoverable, connectable}, 2'h0);
        check({pair_search, pair_advertise}, 2'h2);
        apb(1, `ADDR_MODE, 2);
        peer_u.send(0, "x");
        for (n = 0; n < 40 && connect_req !== 1'h1; n++) idle(1);
        check(connect_req, 1'h1);
        if (n == 40) give_up;
        apb(1, `ADDR_MODE, 32'h10);
        try_in(0, 1);
        check(pair_advertise, 1'h1);
        for (int k = 0; k < 3; k++) begin
            apb(1, `ADDR_RESULT, k);
            expect_rpl(rs[k]);
        end
        leave(0);
        sw_auto_conn <= 1'h1;
        idle(8);
        try_in(0, 0);
        sw_auto_conn <= 1'h0;
        idle(8);
        apb(1, `ADDR_TIMER, 0);
        peer_u.link_up <= 1'h1;
        idle(8);
        try_in(0, 0);
        try_in(1, 0);
        apb(1, `ADDR_TIMER, 253);
        try_in(1, 0);
        try_in(0, 1);
        leave(0);
        apb(1, `ADDR_TIMER, 254);
        try_in(0, 0);
        try_in(1, 1);
        leave(1);
        apb(1, `ADDR_TIMER, 255);
        try_in(1, 1);
        leave(1);
        try_in(0, 1);
        leave(0);
        apb(1, `ADDR_TIMER, 0);
        peer_u.link_up <= 1'h0;
        idle(8);
        try_in(0, 1);
        peer_u.link_up <= 1'h1;
        for (n = 0; n < 30 && cmd_mode !== 1'h0; n++) idle(1);
        check(cmd_mode, 1'h0);
        if (n == 30) give_up;
        tally_and_finish;
    end
endmodule
